// [rtcc_defs.svh]
// Register offsets, field positions, reset values and crystal counts of the calendar clock.
// Assumes inclusion by bare name from the top module.
`ifndef RTCC_DEFS_SVH
`define RTCC_DEFS_SVH
`define RTCC_OFS_IRQ_EN 8'h00
`define RTCC_OFS_CTRL 8'h04
`define RTCC_OFS_STATUS 8'h08
`define RTCC_OFS_ALM_MIN 8'h0c
`define RTCC_OFS_ALM_HOUR 8'h10
`define RTCC_OFS_SEC 8'h14
`define RTCC_OFS_MIN 8'h18
`define RTCC_OFS_HOUR 8'h1c
`define RTCC_OFS_DAY 8'h20
`define RTCC_OFS_MONTH 8'h24
`define RTCC_OFS_YEAR 8'h28
`define RTCC_OFS_DOW 8'h2c
`define RTCC_OFS_CHRONO 8'h30
`define RTCC_BIT_ALARM 7
`define RTCC_BIT_CHRONO 6
`define RTCC_BIT_DAY 5
`define RTCC_BIT_HOUR 4
`define RTCC_BIT_MIN 3
`define RTCC_BIT_SEC 2
`define RTCC_BIT_TB_HALF 1
`define RTCC_BIT_TB_QUARTER 0
`define RTCC_CTRL_CLEAR 0
`define RTCC_CTRL_CHRONO_EN 1
`define RTCC_CTRL_MODULE_EN 2
`define RTCC_CTRL_XTAL_LSB 4
`define RTCC_CNT_32K768 32768
`define RTCC_CNT_32K000 32000
`define RTCC_CNT_38K400 38400
`define RTCC_CNT_64K000 64000
`define RTCC_CNT_76K800 76800
`define RTCC_CHRONO_HZ 100
`define RTCC_CHRONO_HZ_BIN 128
`define RTCC_YEAR_MIN 8'h01
`define RTCC_YEAR_MAX 8'hc7
`define RTCC_RST_DAY 8'h01
`define RTCC_RST_MONTH 8'h01
`define RTCC_RST_YEAR 8'h01
`endif

// [rtcc_pkg.sv]
// Types shared by the calendar clock.
// Assumes the defines header is on the include path.
package rtcc_pkg;
    typedef enum logic [2:0]
    {
        RTCC_XTAL_32K768 = 3'b000,
        RTCC_XTAL_RSVD = 3'b001,
        RTCC_XTAL_32K000 = 3'b010,
        RTCC_XTAL_38K400 = 3'b011,
        RTCC_XTAL_64K000 = 3'b100,
        RTCC_XTAL_76K800 = 3'b101,
        RTCC_XTAL_64K000_B = 3'b110,
        RTCC_XTAL_76K800_B = 3'b111
    } rtcc_xtal_e;
    typedef logic [7:0] rtcc_byte_t;
endpackage

// [rtcc_top.sv]
// Calendar clock with alarm, timebase flags and hundredth-second chronograph, APB slave.
// Assumes crystal_clock is a slow pin clock sampled by clk; stop_mode and osc_in_stop_enable come from clk logic.
`timescale 1ns/1ns
`default_nettype none
`include "rtcc_defs.svh"

module rtcc_top
#(
    parameter int PRESCALE_W = 17,
    parameter int CNT_32K768 = `RTCC_CNT_32K768,
    parameter int CNT_32K000 = `RTCC_CNT_32K000,
    parameter int CNT_38K400 = `RTCC_CNT_38K400,
    parameter int CNT_64K000 = `RTCC_CNT_64K000,
    parameter int CNT_76K800 = `RTCC_CNT_76K800
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Crystal and power state
    input wire logic crystal_clock,
    input wire logic stop_mode,
    input wire logic osc_in_stop_enable,
    // Interrupt request to the processor
    output logic irq
);
    import rtcc_pkg::*;

    // CNT_76K800 and CNT_64K000 must fit the prescaler; each ratio must split evenly into quarters and chronograph ticks.
    if (PRESCALE_W < $clog2(CNT_76K800 + 1) || PRESCALE_W < $clog2(CNT_64K000 + 1)
        || CNT_32K768 % `RTCC_CHRONO_HZ_BIN != 0
        || CNT_32K000 % `RTCC_CHRONO_HZ != 0 || CNT_38K400 % `RTCC_CHRONO_HZ != 0
        || CNT_64K000 % `RTCC_CHRONO_HZ != 0 || CNT_76K800 % `RTCC_CHRONO_HZ != 0
        || CNT_32K768 % 4 != 0 || CNT_32K000 % 4 != 0 || CNT_38K400 % 4 != 0
        || CNT_64K000 % 4 != 0 || CNT_76K800 % 4 != 0)
    begin : g_bad_params
        $error("rtcc_top: prescaler parameters unusable");
    end

    logic pready_reg, pslverr_reg, irq_reg;
    logic [31:0] prdata_reg;
    logic [1:0] xsync_reg;
    logic xlast_reg;
    logic [7:0] irq_en_reg, flags_reg, armed_reg, alm_min_reg, alm_hour_reg;
    logic [7:0] sec_reg, min_reg, hour_reg, day_reg, month_reg, year_reg, dow_reg;
    logic module_en_reg, chrono_en_reg, xtal_locked_reg, alarm_match_reg;
    rtcc_xtal_e xtal_reg;
    logic [PRESCALE_W-1:0] pre_reg, chr_pre_reg;
    logic [6:0] chrono_reg;

    // Bus phases: one wait state, so every answer comes from a flop.
    wire access = psel && penable && !pready_reg;
    wire done = psel && penable && pready_reg;
    wire wr = done && pwrite;
    wire rd = done && !pwrite;
    wire [7:0] wbyte = pwdata[7:0];
    wire sel_en = paddr == `RTCC_OFS_IRQ_EN;
    wire sel_ctrl = paddr == `RTCC_OFS_CTRL;
    wire sel_stat = paddr == `RTCC_OFS_STATUS;
    wire sel_amin = paddr == `RTCC_OFS_ALM_MIN;
    wire sel_ahour = paddr == `RTCC_OFS_ALM_HOUR;
    wire sel_sec = paddr == `RTCC_OFS_SEC;
    wire sel_min = paddr == `RTCC_OFS_MIN;
    wire sel_hour = paddr == `RTCC_OFS_HOUR;
    wire sel_day = paddr == `RTCC_OFS_DAY;
    wire sel_month = paddr == `RTCC_OFS_MONTH;
    wire sel_year = paddr == `RTCC_OFS_YEAR;
    wire sel_dow = paddr == `RTCC_OFS_DOW;
    wire sel_chr = paddr == `RTCC_OFS_CHRONO;
    wire mapped = sel_en || sel_ctrl || sel_stat || sel_amin || sel_ahour || sel_sec || sel_min
        || sel_hour || sel_day || sel_month || sel_year || sel_dow || sel_chr;

    // Stop without the oscillator option freezes every counter but keeps state.
    wire run = module_en_reg && !(stop_mode && !osc_in_stop_enable);
    wire xedge = xsync_reg[1] && !xlast_reg;
    wire tick = run && xedge;

    // Crystal edges per second; reserved code falls back to the 32.768 kHz ratio.
    wire bin_mode = xtal_reg == RTCC_XTAL_32K768 || xtal_reg == RTCC_XTAL_RSVD;
    wire [PRESCALE_W-1:0] per_sec =
        bin_mode ? PRESCALE_W'(CNT_32K768) :
        xtal_reg == RTCC_XTAL_32K000 ? PRESCALE_W'(CNT_32K000) :
        xtal_reg == RTCC_XTAL_38K400 ? PRESCALE_W'(CNT_38K400) :
        xtal_reg[0] ? PRESCALE_W'(CNT_76K800) : PRESCALE_W'(CNT_64K000);
    wire [PRESCALE_W-1:0] chr_div = bin_mode ? PRESCALE_W'(CNT_32K768 / `RTCC_CHRONO_HZ_BIN) :
        xtal_reg == RTCC_XTAL_32K000 ? PRESCALE_W'(CNT_32K000 / `RTCC_CHRONO_HZ) :
        xtal_reg == RTCC_XTAL_38K400 ? PRESCALE_W'(CNT_38K400 / `RTCC_CHRONO_HZ) :
        xtal_reg[0] ? PRESCALE_W'(CNT_76K800 / `RTCC_CHRONO_HZ) : PRESCALE_W'(CNT_64K000 / `RTCC_CHRONO_HZ);
    wire [PRESCALE_W-1:0] quarter = per_sec >> 2;
    wire pre_end = pre_reg == per_sec - 1'b1;
    wire sec_tick = tick && pre_end;
    wire half_tick = tick && (pre_end || pre_reg == (quarter << 1) - 1'b1);
    wire quarter_tick = tick && (pre_end || pre_reg == quarter - 1'b1
        || pre_reg == (quarter << 1) - 1'b1 || pre_reg == (quarter << 1) + quarter - 1'b1);

    // Calendar carries.
    wire leap = year_reg[1:0] == 2'b00;
    wire [7:0] mdays = month_reg == 8'h02 ? (leap ? 8'h1d : 8'h1c) :
        (month_reg == 8'h04 || month_reg == 8'h06 || month_reg == 8'h09 || month_reg == 8'h0b) ? 8'h1e : 8'h1f;
    wire min_tick = sec_tick && sec_reg == 8'h3b;
    wire hour_tick = min_tick && min_reg == 8'h3b;
    wire day_tick = hour_tick && hour_reg == 8'h17;
    wire month_tick = day_tick && day_reg >= mdays;
    wire year_tick = month_tick && month_reg == 8'h0c;
    wire [7:0] year_inc = year_reg == `RTCC_YEAR_MAX ? `RTCC_YEAR_MIN : year_reg + 8'h01;

    // Chronograph: binary mode ticks at 128 Hz and the stored value is scaled to 10 ms units.
    wire chr_run = tick && chrono_en_reg;
    wire chr_end = chr_pre_reg == chr_div - 1'b1;
    wire chr_tick = chr_run && chr_end;
    wire [6:0] chr_top = bin_mode ? 7'h7f : 7'h63;
    wire [13:0] chr_scaled = 14'(chrono_reg) * 14'h0064;
    wire [7:0] chrono_data = bin_mode ? {1'b0, chr_scaled[13:7]} : {1'b0, chrono_reg};
    wire chr_clear = wr && sel_ctrl && wbyte[`RTCC_CTRL_CLEAR];

    // Alarm fires once as the counters move onto the alarm time.
    wire alarm_match = min_reg == alm_min_reg && hour_reg == alm_hour_reg;
    wire alarm_set = alarm_match && !alarm_match_reg;

    wire [7:0] set_vec = {alarm_set, chr_tick, day_tick, hour_tick, min_tick, sec_tick,
        half_tick, quarter_tick};
    wire [7:0] data_rd = {rd && sel_ahour, rd && sel_chr, rd && sel_day, rd && sel_hour,
        rd && sel_min, rd && sel_sec, rd && sel_chr, rd && sel_chr};
    wire [7:0] clr_vec = armed_reg & data_rd;
    wire [7:0] flags_next = set_vec | (flags_reg & ~clr_vec);
    wire [7:0] armed_next = (armed_reg & ~clr_vec) | ((rd && sel_stat) ? flags_reg : 8'h00);

    // Validated loads; illegal values are dropped.
    wire ld_sec = wr && sel_sec && wbyte <= 8'h3b;
    wire ld_min = wr && sel_min && wbyte <= 8'h3b;
    wire ld_hour = wr && sel_hour && wbyte <= 8'h17;
    wire ld_day = wr && sel_day && wbyte != 8'h00 && wbyte <= mdays;
    wire ld_month = wr && sel_month && wbyte != 8'h00 && wbyte <= 8'h0c;
    wire ld_year = wr && sel_year && wbyte >= `RTCC_YEAR_MIN && wbyte <= `RTCC_YEAR_MAX;
    wire ld_dow = wr && sel_dow && wbyte <= 8'h06;
    wire [7:0] ctrl_rd = {1'b0, 3'(xtal_reg), 1'b0, module_en_reg, chrono_en_reg, 1'b0};

    wire [7:0] rd_mux = sel_en ? irq_en_reg : sel_ctrl ? ctrl_rd : sel_stat ? flags_reg :
        sel_amin ? alm_min_reg : sel_ahour ? alm_hour_reg : sel_sec ? sec_reg : sel_min ? min_reg :
        sel_hour ? hour_reg : sel_day ? day_reg : sel_month ? month_reg : sel_year ? year_reg :
        sel_dow ? dow_reg : sel_chr ? chrono_data : 8'h00;

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end
        else
        begin
            pready_reg <= access;
            pslverr_reg <= access && !mapped;
            prdata_reg <= access && !pwrite ? {24'h0, rd_mux} : 32'h0;
        end
    end

    // Crystal pin synchroniser; only the second stage feeds the edge detector.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            xsync_reg <= 2'b00;
            xlast_reg <= 1'b0;
        end
        else
        begin
            xsync_reg <= {xsync_reg[0], crystal_clock};
            xlast_reg <= xsync_reg[1];
        end
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            irq_en_reg <= 8'h00;
            module_en_reg <= 1'b0;
            chrono_en_reg <= 1'b0;
            xtal_reg <= RTCC_XTAL_32K768;
            xtal_locked_reg <= 1'b0;
            alm_min_reg <= 8'h00;
            alm_hour_reg <= 8'h00;
        end
        else
        begin
            if (wr && sel_en)
                irq_en_reg <= wbyte;
            if (wr && sel_ctrl)
            begin
                module_en_reg <= wbyte[`RTCC_CTRL_MODULE_EN];
                chrono_en_reg <= wbyte[`RTCC_CTRL_CHRONO_EN];
                xtal_locked_reg <= 1'b1;
                if (!xtal_locked_reg)
                    xtal_reg <= rtcc_xtal_e'(wbyte[`RTCC_CTRL_XTAL_LSB +: 3]);
            end
            if (wr && sel_amin)
                alm_min_reg <= wbyte;
            if (wr && sel_ahour)
                alm_hour_reg <= wbyte;
        end
    end

    // Prescalers and chronograph.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            pre_reg <= '0;
            chr_pre_reg <= '0;
            chrono_reg <= 7'h00;
        end
        else
        begin
            if (tick)
                pre_reg <= pre_end ? '0 : pre_reg + 1'b1;
            if (chr_clear)
            begin
                chr_pre_reg <= '0;
                chrono_reg <= 7'h00;
            end
            else if (chr_run)
            begin
                chr_pre_reg <= chr_end ? '0 : chr_pre_reg + 1'b1;
                if (chr_end)
                    chrono_reg <= chrono_reg >= chr_top ? 7'h00 : chrono_reg + 7'h01;
            end
        end
    end

    // Time and date; a software load wins over a tick in the same cycle.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            sec_reg <= 8'h00;
            min_reg <= 8'h00;
            hour_reg <= 8'h00;
            day_reg <= `RTCC_RST_DAY;
            month_reg <= `RTCC_RST_MONTH;
            year_reg <= `RTCC_RST_YEAR;
            dow_reg <= 8'h00;
        end
        else
        begin
            if (ld_sec)
                sec_reg <= wbyte;
            else if (sec_tick)
                sec_reg <= min_tick ? 8'h00 : sec_reg + 8'h01;
            if (ld_min)
                min_reg <= wbyte;
            else if (min_tick)
                min_reg <= hour_tick ? 8'h00 : min_reg + 8'h01;
            if (ld_hour)
                hour_reg <= wbyte;
            else if (hour_tick)
                hour_reg <= day_tick ? 8'h00 : hour_reg + 8'h01;
            if (ld_day)
                day_reg <= wbyte;
            else if (day_tick)
                day_reg <= month_tick ? 8'h01 : day_reg + 8'h01;
            if (ld_dow)
                dow_reg <= wbyte;
            else if (day_tick)
                dow_reg <= dow_reg == 8'h06 ? 8'h00 : dow_reg + 8'h01;
            if (ld_month)
                month_reg <= wbyte;
            else if (month_tick)
                month_reg <= year_tick ? 8'h01 : month_reg + 8'h01;
            if (ld_year)
                year_reg <= wbyte;
            else if (year_tick)
                year_reg <= year_inc;
        end
    end

    // Flags: a new event in the clearing cycle keeps the flag set.
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            flags_reg <= 8'h00;
            armed_reg <= 8'h00;
            alarm_match_reg <= 1'b0;
            irq_reg <= 1'b0;
        end
        else
        begin
            flags_reg <= flags_next;
            armed_reg <= armed_next;
            alarm_match_reg <= alarm_match;
            irq_reg <= |(flags_next & irq_en_reg);
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq = irq_reg;
endmodule // rtcc_top
`default_nettype wire

// [rtcc_chk.sv]
// Port-level assertions for the calendar clock: APB answer timing, error and read-data rules, irq masking.
// Assumes one clk domain with synchronous active-low rst_n.
`timescale 1ns/1ns
`default_nettype none
module rtcc_chk
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Interrupt
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    wire mapped = (paddr <= 8'h30) && (paddr[1:0] == 2'h0);
    wire rd_done = pready && !pwrite;
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_access;
        psel && penable && !pready;
    endsequence
    property p_answer;
        s_setup ##1 s_access |=> pready;
    endproperty
    property p_pulse;
        pready |=> !pready;
    endproperty
    property p_cause;
        pready |-> $past(psel && penable);
    endproperty
    property p_err;
        pready && !mapped |-> pslverr && prdata == 32'h0;
    endproperty
    property p_ok;
        pready && mapped |-> !pslverr && prdata[31:8] == 24'h0;
    endproperty
    property p_idle;
        !pready |-> prdata == 32'h0 && !pslverr;
    endproperty
    property p_chrono;
        rd_done && paddr == 8'h30 |-> prdata <= 32'h63;
    endproperty
    property p_clr;
        rd_done && paddr == 8'h04 |-> prdata[0] == 1'b0;
    endproperty
    property p_irq_off;
        pready && pwrite && paddr == 8'h00 && pwdata[7:0] == 8'h00 |-> ##[1:2] !irq;
    endproperty
    a_answer: assert property (p_answer) else $error("pready late");
    a_pulse: assert property (p_pulse) else $error("pready too long");
    a_cause: assert property (p_cause) else $error("pready without access");
    a_err: assert property (p_err) else $error("unmapped not refused");
    a_ok: assert property (p_ok) else $error("mapped access refused");
    a_idle: assert property (p_idle) else $error("read data outside answer");
    a_chrono: assert property (p_chrono) else $error("chrono above 99");
    a_clr: assert property (p_clr) else $error("clear bit reads one");
    a_irq_off: assert property (p_irq_off) else $error("irq with no enable");
endmodule // rtcc_chk
bind rtcc_top rtcc_chk u_chk (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
`default_nettype wire

// [tb.sv]
// Self-checking bench for the calendar clock, driving APB, crystal pin and power state.
// Assumes short per-second crystal counts so a second lasts 2048 clk cycles.
`timescale 1ns/1ns
`default_nettype none
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic crystal_clock = 1'b0;
    logic stop_mode = 1'b0;
    logic osc_in_stop_enable = 1'b0;
    logic irq;
    logic [1:0] xdiv = 2'h0;
    logic last_err;
    logic [31:0] rv;
    logic [31:0] held;
    logic [7:0] wa [8] = '{8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h0c, 8'h10};
    logic [7:0] wd [8] = '{8'h3b, 8'h3b, 8'h17, 8'h1c, 8'h02, 8'h64, 8'h00, 8'h00};
    int errors = 0;
    int checked = 0;
    rtcc_top #(.CNT_32K768(512), .CNT_32K000(400), .CNT_38K400(400), .CNT_64K000(400), .CNT_76K800(400)) DUT
    (
        .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .crystal_clock(crystal_clock),
        .stop_mode(stop_mode), .osc_in_stop_enable(osc_in_stop_enable), .irq(irq)
    );
    initial forever #5 clk = ~clk;
    // The crystal runs at a quarter of clk so the two-flop sync never misses an edge.
    always @(posedge clk)
    begin
        xdiv <= xdiv + 2'h1;
        crystal_clock <= xdiv[1];
    end
    task automatic finish_test();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] ad, input logic [31:0] d);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1)
        begin
            chk("pready", {31'h0, pready}, 32'h1);
            finish_test();
        end
        rv = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        xfer(1'b1, ad, {24'h0, d});
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] e);
        xfer(1'b0, ad, 32'h0);
        chk($sformatf("reg %h", ad), rv, e);
    endtask
    // Longer than one second, so a running counter must have moved.
    task automatic freeze(input logic same);
        logic [31:0] s;
        xfer(1'b0, 8'h14, 32'h0);
        s = rv;
        repeat (2500) @(posedge clk);
        xfer(1'b0, 8'h14, 32'h0);
        chk("sec held", {31'h0, rv === s}, {31'h0, same});
    endtask
    initial
    begin
        repeat (100000) @(posedge clk);
        chk("watchdog", 32'h0, 32'h1);
        finish_test();
    end
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h00, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h20, 32'h1);
        rd(8'h28, 32'h1);
        rd(8'h40, 32'h0);
        chk("slverr", {31'h0, last_err}, 32'h1);
        wr(8'h00, 8'hff);
        rd(8'h00, 32'hff);
        wr(8'h00, 8'ha0);
        wr(8'h04, 8'h00);
        wr(8'h04, 8'h20);
        rd(8'h04, 32'h0);
        foreach (wa[i])
            wr(wa[i], wd[i]);
        freeze(1'b1);
        wr(8'h04, 8'h06);
        for (int i = 0; i < 1000; i++)
        begin
            xfer(1'b0, 8'h08, 32'h0);
            if (rv[2] === 1'b1)
                break;
        end
        if (rv[2] !== 1'b1)
        begin
            chk("second poll", 32'h0, 32'h1);
            finish_test();
        end
        rd(8'h08, 32'hff);
        chk("irq", {31'h0, irq}, 32'h1);
        rd(8'h14, 32'h0);
        rd(8'h18, 32'h0);
        rd(8'h1c, 32'h0);
        rd(8'h20, 32'h1d);
        rd(8'h24, 32'h2);
        rd(8'h2c, 32'h1);
        rd(8'h10, 32'h0);
        xfer(1'b0, 8'h08, 32'h0);
        chk("flags cleared", rv & 32'hbc, 32'h0);
        repeat (2) @(posedge clk);
        chk("irq", {31'h0, irq}, 32'h0);
        wr(8'h20, 8'h1e);
        wr(8'h1c, 8'h18);
        wr(8'h24, 8'h0d);
        wr(8'h28, 8'hc8);
        rd(8'h20, 32'h1d);
        rd(8'h1c, 32'h0);
        rd(8'h24, 32'h2);
        rd(8'h28, 32'h64);
        wr(8'h04, 8'h04);
        // Arm the flags so the chronograph read below clears the timebase and chronograph flags.
        xfer(1'b0, 8'h08, 32'h0);
        xfer(1'b0, 8'h30, 32'h0);
        held = rv;
        repeat (1000) @(posedge clk);
        rd(8'h30, held);
        xfer(1'b0, 8'h08, 32'h0);
        chk("quarter set, chrono idle", rv & 32'h41, 32'h1);
        wr(8'h04, 8'h05);
        rd(8'h30, 32'h0);
        rd(8'h04, 32'h4);
        wr(8'h04, 8'h06);
        repeat (1024) @(posedge clk);
        xfer(1'b0, 8'h30, 32'h0);
        chk("chrono", {31'h0, rv >= 32'h2f && rv <= 32'h35}, 32'h1);
        stop_mode <= 1'b1;
        freeze(1'b1);
        osc_in_stop_enable <= 1'b1;
        freeze(1'b0);
        // Software parks the block during stop mode; it must stand still even with the oscillator kept.
        wr(8'h04, 8'h00);
        freeze(1'b1);
        wr(8'h00, 8'h00);
        rd(8'h00, 32'h0);
        // A second reset after software has parked the block must bring the chronograph back to zero and keep the control bits at zero.
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(8'h04, 32'h0);
        rd(8'h30, 32'h0);
        finish_test();
    end
endmodule // tb
`default_nettype wire
